// [hw/dtd_regs.svh]
// register offsets, field positions, reset values and step counts of the dialler
`ifndef DTD_REGS_SVH
`define DTD_REGS_SVH

// ****************************************
// register map (byte addresses)
// ****************************************
`define DTD_CTRL_ADDR 4'h0
`define DTD_STAT_ADDR 4'h4
`define DTD_CTRL_RST 32'h0000_0001
`define DTD_CTRL_TONE_EN 0
`define DTD_STAT_BUSY 0
`define DTD_STAT_MICRO 1
`define DTD_STAT_MUTE 2
`define DTD_STAT_LIDX 3
`define DTD_STAT_HIDX 5
`define DTD_STAT_LON 7
`define DTD_STAT_HON 8

// ****************************************
// prescaler: first stage 3 or 4 (build time), second stage fixed 3
// ****************************************
`define DTD_PRE1_DIV 3'd3
`define DTD_PRE2_DIV 2'd3

// ****************************************
// key timing, in lower-group tone periods
// ****************************************
`define DTD_BURST_PERIODS 2'd2
`define DTD_RELEASE_PERIODS 2'd2

// ****************************************
// staircase steps and step lengths in tone-clock cycles
// ****************************************
`define DTD_LOW_STEPS 5'd14
`define DTD_HIGH_STEPS 5'd18
`define DTD_L0_LEN 6'd41
`define DTD_L0_END 6'd40
`define DTD_L1_LEN 6'd37
`define DTD_L2_LEN 6'd33
`define DTD_L2_END 6'd36
`define DTD_L3_LEN 6'd30
`define DTD_L3_END 6'd32
`define DTD_H0_LEN 6'd18
`define DTD_H0_END 6'd21
`define DTD_H1_LEN 6'd16
`define DTD_H1_END 6'd21
`define DTD_H2_LEN 6'd15
`define DTD_H3_LEN 6'd13
`define DTD_H3_END 6'd18

`endif

// [hw/dtd_pkg.sv]
// types shared by the dialler logic
package dtd_pkg;
    typedef enum logic [1:0] {
        DTD_IDLE = 2'b00,
        DTD_BURST = 2'b01,
        DTD_HOLD = 2'b10
    } dtd_state_t;

    typedef logic [1:0] dtd_idx_t;
endpackage

// [hw/dtd_tone_div.sv]
// programmable staircase divider for one tone group
`timescale 1ns/1ns
`include "dtd_regs.svh"
module dtd_tone_div
    import dtd_pkg::*;
#(
    parameter bit HIGH_GRP = 1'b0
) (
    // clocking
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    input wire logic tick,
    // control
    input wire logic run,
    input wire dtd_idx_t sel,
    // staircase position
    output logic [4:0] step_q,
    output logic period_end_q
);
    logic [5:0] cnt_q;
    logic [5:0] len;
    logic [4:0] nsteps;
    logic edge_step;

    // end steps (lowest and highest level) carry the odd length
    assign nsteps = HIGH_GRP ? `DTD_HIGH_STEPS : `DTD_LOW_STEPS;
    assign edge_step = (step_q == 5'h00) || (step_q == (nsteps >> 1));

    always_comb begin
        len = `DTD_L1_LEN;
        if (!HIGH_GRP) begin
            case (sel)
                2'd0: len = edge_step ? `DTD_L0_END : `DTD_L0_LEN;
                2'd1: len = `DTD_L1_LEN;
                2'd2: len = edge_step ? `DTD_L2_END : `DTD_L2_LEN;
                default: len = edge_step ? `DTD_L3_END : `DTD_L3_LEN;
            endcase
        end else begin
            case (sel)
                2'd0: len = edge_step ? `DTD_H0_END : `DTD_H0_LEN;
                2'd1: len = edge_step ? `DTD_H1_END : `DTD_H1_LEN;
                2'd2: len = `DTD_H2_LEN;
                default: len = edge_step ? `DTD_H3_END : `DTD_H3_LEN;
            endcase
        end
    end

    // step counter wraps after 14 or 18 steps
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= 6'h00;
            step_q <= 5'h00;
            period_end_q <= 1'b0;
        end else if (ce) begin
            period_end_q <= 1'b0;
            if (!run) begin
                cnt_q <= 6'h00;
                step_q <= 5'h00;
            end else if (tick) begin
                if (cnt_q == len - 6'd1) begin
                    cnt_q <= 6'h00;
                    if (step_q == nsteps - 5'd1) begin
                        step_q <= 5'h00;
                        period_end_q <= 1'b1;
                    end else begin
                        step_q <= step_q + 5'd1;
                    end
                end else begin
                    cnt_q <= cnt_q + 6'd1;
                end
            end
        end
    end
endmodule

// [hw/dtd_top.sv]
// keypad input logic, prescaler and tone dividers of the dialler
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`include "dtd_regs.svh"
module dtd_top
    import dtd_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // tone select pins
    input wire logic [3:0] row_sel_n,
    input wire logic [3:0] col_sel,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // tone generator outputs
    output logic low_on,
    output logic high_on,
    output logic [4:0] low_step,
    output logic [4:0] high_step,
    output logic mute
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    // metastability guard on the eight select pins
    logic [3:0] row_m_q;
    logic [3:0] row_s_q;
    logic [3:0] col_m_q;
    logic [3:0] col_s_q;

    // two stages, only the second is read
    // reset to the released levels so no false press follows reset
    // a contact that bounces across a tick is simply seen on the next one
    always_ff @(posedge mclk) begin
        if (srst) begin
            row_m_q <= 4'hf;
            row_s_q <= 4'hf;
            col_m_q <= 4'h0;
            col_s_q <= 4'h0;
        end else if (ce) begin
            row_m_q <= row_sel_n;
            row_s_q <= row_m_q;
            col_m_q <= col_sel;
            col_s_q <= col_m_q;
        end
    end

    // ****************************************
    // prescaler
    // ****************************************
    // stage counters and the tone-clock tick
    logic [1:0] pre1_q;
    logic [1:0] pre2_q;
    logic tick_q;

    // first stage 3 or 4, second stage 3
    // overall 9 or 12
    // tick is one cycle wide; ce low stretches the tone clock with it
    always_ff @(posedge mclk) begin
        if (srst) begin
            pre1_q <= 2'd0;
            pre2_q <= 2'd0;
            tick_q <= 1'b0;
        end else if (ce) begin
            tick_q <= 1'b0;
            // compared one bit wider so the divide-by-4 build fits
            if ({1'b0, pre1_q} == `DTD_PRE1_DIV - 3'd1) begin
                pre1_q <= 2'd0;
                if (pre2_q == `DTD_PRE2_DIV - 2'd1) begin
                    pre2_q <= 2'd0;
                    tick_q <= 1'b1;
                end else begin
                    pre2_q <= pre2_q + 2'd1;
                end
            end else begin
                pre1_q <= pre1_q + 2'd1;
            end
        end
    end

    // ****************************************
    // input decode
    // ****************************************
    // decoded pin state, all taken from the synced copies
    logic [3:0] row_act;
    logic [3:0] col_act;
    logic micro_mode;
    logic micro_en;
    logic any_row;
    logic any_col;
    dtd_idx_t micro_lidx;
    dtd_idx_t micro_hidx;

    assign row_act = ~row_s_q;
    assign col_act = col_s_q;
    // any closed line on either side
    assign any_row = |row_act;
    assign any_col = |col_act;
    // keypad mode unless lines one, two and four all high
    // then line three enables and rows are a code
    // a full pad with three columns held also lands here; accepted
    assign micro_mode = col_s_q[0] & col_s_q[1] & col_s_q[3];
    assign micro_en = col_s_q[2];
    // HH selects the first tone, LL the last
    // code lines pass the same synchroniser, so a new code settles in two cycles
    assign micro_lidx = ~row_s_q[3:2];
    assign micro_hidx = ~row_s_q[1:0];

    // lowest active line wins when several close in the same sample
    // no line at all returns 3, but then the group flag stays clear
    function automatic dtd_idx_t first_idx(input logic [3:0] v);
        dtd_idx_t r;
        r = 2'd3;
        if (v[2]) r = 2'd2;
        if (v[1]) r = 2'd1;
        if (v[0]) r = 2'd0;
        return r;
    endfunction

    // ****************************************
    // keypad sequencer
    // ****************************************
    // idle waits for a press, burst holds two periods, hold watches release
    dtd_state_t state_q;
    dtd_idx_t key_lidx_q;
    dtd_idx_t key_hidx_q;
    logic key_low_q;
    logic key_high_q;
    logic [1:0] per_cnt_q;
    logic [1:0] rel_cnt_q;
    logic key_held;
    logic low_period_end;

    // latched key is still down: only its own lines are looked at
    assign key_held = (!key_low_q || row_act[key_lidx_q]) &&
                      (!key_high_q || col_act[key_hidx_q]);

    // every keypad decision taken on a tone-clock tick or period end; micro mode forces idle on any cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= DTD_IDLE;
            key_lidx_q <= 2'd0;
            key_hidx_q <= 2'd0;
            key_low_q <= 1'b0;
            key_high_q <= 1'b0;
            per_cnt_q <= 2'd0;
            rel_cnt_q <= 2'd0;
        end else if (ce) begin
            // leaving micro mode restarts from idle, a held key is a fresh press
            if (micro_mode) begin
                state_q <= DTD_IDLE;
            end else begin
                case (state_q)
                    DTD_IDLE: begin
                        // start on the first tick that sees a press
                        // a still-held second key starts here after stop
                        if (tick_q && (any_row || any_col)) begin
                            state_q <= DTD_BURST;
                            key_lidx_q <= first_idx(row_act);
                            key_hidx_q <= first_idx(col_act);
                            // a lone line gives a lone tone
                            key_low_q <= any_row;
                            key_high_q <= any_col;
                            per_cnt_q <= 2'd0;
                            rel_cnt_q <= 2'd0;
                        end
                    end
                    DTD_BURST: begin
                        // two whole lower periods before sampling again
                        // other inputs ignored, nothing re-latched here
                        // per_cnt_q counts finished lower periods since the start
                        if (low_period_end) begin
                            if (per_cnt_q == `DTD_BURST_PERIODS - 2'd1) begin
                                state_q <= DTD_HOLD;
                            end else begin
                                per_cnt_q <= per_cnt_q + 2'd1;
                            end
                        end
                    end
                    DTD_HOLD: begin
                        // release must last beyond one lower period, seen at two successive period ends
                        // a key lifted and pressed again between samples counts as held
                        if (low_period_end) begin
                            if (key_held) begin
                                rel_cnt_q <= 2'd0;
                            end else if (rel_cnt_q == `DTD_RELEASE_PERIODS - 2'd1) begin
                                state_q <= DTD_IDLE;
                                rel_cnt_q <= 2'd0;
                            end else begin
                                rel_cnt_q <= rel_cnt_q + 2'd1;
                            end
                        end
                    end
                    default: state_q <= DTD_IDLE;
                endcase
            end
        end
    end

    // ****************************************
    // tone selection and dividers
    // ****************************************
    // divider controls and step taps
    logic key_busy;
    logic low_run;
    logic high_run;
    dtd_idx_t lidx;
    dtd_idx_t hidx;
    logic [4:0] low_step_w;
    logic [4:0] high_step_w;

    // busy only for keypad bursts; micro mode drives the dividers itself
    assign key_busy = (state_q != DTD_IDLE) && !micro_mode;
    // lower divider also paces a high-only burst, its output is gated instead
    assign low_run = micro_mode ? micro_en : key_busy;
    assign high_run = micro_mode ? micro_en : (key_busy && key_high_q);
    // micro code goes straight to the dividers, keypad uses the latched key
    assign lidx = micro_mode ? micro_lidx : key_lidx_q;
    assign hidx = micro_mode ? micro_hidx : key_hidx_q;

    dtd_tone_div #(
        .HIGH_GRP(1'b0)
    ) u_low_div (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .tick(tick_q),
        .run(low_run),
        .sel(lidx),
        .step_q(low_step_w),
        .period_end_q(low_period_end)
    );

    dtd_tone_div #(
        .HIGH_GRP(1'b1)
    ) u_high_div (
        .mclk(mclk),
        .srst(srst),
        .ce(ce),
        .tick(tick_q),
        .run(high_run),
        .sel(hidx),
        .step_q(high_step_w),
        // all key timing follows the lower group, so this end is not needed
        .period_end_q()
    );

    // ****************************************
    // register file
    // ****************************************
    // one stored bit, the rest of the map is live status
    logic tone_en_q;
    logic [31:0] stat_w;

    // bit order follows the status field positions
    assign stat_w = {23'h0, high_on, low_on, hidx, lidx, mute, micro_mode, key_busy};

    // waitrequest drops for one cycle, one cycle after a request appears
    // each access costs two cycles; no pipelining, so no response queue
    always_ff @(posedge mclk) begin
        if (srst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else if (ce) begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                case (address)
                    `DTD_CTRL_ADDR: readdata <= {31'h0, tone_en_q};
                    `DTD_STAT_ADDR: readdata <= stat_w;
                    default: readdata <= 32'h0;
                endcase
            end
        end
    end

    // control write lands on the edge that sees waitrequest low
    // limitation: ce low on that very edge loses the write, so keep ce high
    // while a bus access is in flight
    always_ff @(posedge mclk) begin
        if (srst) begin
            tone_en_q <= |(`DTD_CTRL_RST & (32'h1 << `DTD_CTRL_TONE_EN));
        end else if (ce) begin
            if (write && !waitrequest && address == `DTD_CTRL_ADDR) begin
                tone_en_q <= writedata[`DTD_CTRL_TONE_EN];
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // registered so the pins never glitch on mode changes
    // steps follow the dividers one cycle late, in line with the on flags
    always_ff @(posedge mclk) begin
        if (srst) begin
            // speech mode, no tones, mute off
            low_on <= 1'b0;
            high_on <= 1'b0;
            low_step <= 5'h00;
            high_step <= 5'h00;
            mute <= 1'b0;
        end else if (ce) begin
            // lone tone: the other group stays off
            low_on <= tone_en_q && low_run && (micro_mode || key_low_q);
            high_on <= tone_en_q && high_run;
            low_step <= low_step_w;
            high_step <= high_step_w;
            // three high lines mute even with enable low
            mute <= key_busy || micro_mode;
        end
    end
endmodule

// [bench/dtd_top_assertions.sv]
// concurrent checks on the dialler top-level ports
`timescale 1ns/1ns
module dtd_chk (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // pins and bus
    input wire logic [3:0] col_sel,
    input wire logic [3:0] row_sel_n,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // tone outputs
    input wire logic low_on,
    input wire logic high_on,
    input wire logic [4:0] low_step,
    input wire logic [4:0] high_step,
    input wire logic mute
);
    // two periods of the shortest lower tone, less sync slack
    localparam int BURST_MIN = 7600;
    logic [15:0] on_cnt_q;
    logic micro;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // columns one, two and four high mean microcomputer drive
    assign micro = col_sel[0] && col_sel[1] && col_sel[3];

    // length of the running burst, saturating so it never wraps
    always_ff @(posedge mclk) begin
        if (srst || !(low_on || high_on)) begin
            on_cnt_q <= 16'h0;
        end else if (on_cnt_q != 16'hffff) begin
            on_cnt_q <= on_cnt_q + 16'h1;
        end
    end

    // ********
    // checks
    // ********
    sequence bus_req;
        (read || write) && waitrequest && ce;
    endsequence
    sequence bus_ans;
        !waitrequest ##1 waitrequest;
    endsequence
    // one-cycle answer on the bus
    bus_answer_a: assert property (bus_req |=> bus_ans)
        else $error("bus request not answered in one cycle");
    // read data only moves with a read answer
    rdata_hold_a: assert property ($changed(readdata) |-> $fell(waitrequest) && $past(read))
        else $error("read data moved outside a read answer");
    reset_idle_a: assert property (disable iff (1'b0) srst && ce |=> waitrequest
        && !low_on && !high_on && !mute && low_step == 5'h0 && high_step == 5'h0)
        else $error("outputs not idle after reset");
    mute_tone_a: assert property (low_on || high_on |-> mute)
        else $error("tone without mute");
    steps_range_a: assert property (low_step < 5'd14 && high_step < 5'd18)
        else $error("staircase step out of range");
    press_start_a: assert property ($rose(row_sel_n != 4'hf) && !micro && !mute
        |-> ##[1:16] low_on)
        else $error("key press did not start the tone");
    burst_min_a: assert property ($fell(low_on || high_on) && !micro
        |-> on_cnt_q >= BURST_MIN)
        else $error("tone burst too short");
    step_dwell_a: assert property ($changed(high_step) && high_on
        |=> ($stable(high_step) || !high_on) [*8])
        else $error("high step moved between tone-clock ticks");
    low_order_a: assert property ($changed(low_step) && low_on && $past(low_on)
        |-> low_step == $past(low_step) + 5'd1 || low_step == 5'd0)
        else $error("lower step skipped");
endmodule

bind dtd_top dtd_chk i_chk (.mclk, .srst, .ce, .col_sel, .row_sel_n, .read, .write, .readdata,
    .waitrequest, .low_on, .high_on, .low_step, .high_step, .mute);

// [bench/dtd_keypad.sv]
// keypad and microcomputer model driving the tone select pins
`timescale 1ns/1ns
module dtd_keypad (
    // key contacts, one bit per line, high = closed
    input wire logic [3:0] press_row,
    input wire logic [3:0] press_col,
    // microcomputer drive
    input wire logic micro,
    input wire logic [3:0] code,
    input wire logic tone_en,
    // select pins
    output logic [3:0] row_sel_n,
    output logic [3:0] col_sel
);
    // pin levels
    // released rows sit on their pull-up, released columns on their pull-down
    always_comb begin
        if (micro) begin
            row_sel_n = code;
            col_sel = {1'b1, tone_en, 2'b11};
        end else begin
            row_sel_n = ~press_row;
            col_sel = press_col;
        end
    end
endmodule

// [bench/test_dtd_top.sv]
// self-checking bench for the dialler keypad logic
`timescale 1ns/1ns
`include "dtd_regs.svh"
module test_dtd_top;
    import dtd_pkg::*;
    localparam int PRE = `DTD_PRE1_DIV * `DTD_PRE2_DIV;
    logic mclk, srst, ce, read, write, waitrequest, low_on, high_on, mute, micro, tone_en;
    logic [3:0] address, row_sel_n, col_sel, press_row, press_col, code, c;
    logic [31:0] writedata, readdata, q, r;
    logic [31:0] rng = 32'h53;
    logic [4:0] low_step, high_step, lp, hp;
    logic [1:0] li, hi;
    int lo_div [4] = '{572, 518, 468, 424};
    int hi_div [4] = '{330, 298, 270, 244};
    int mismatches = 0;
    int num_checks = 0;
    int lc = 0, hc = 0, lo_per = 0, hi_per = 0, n, nf;

    dtd_top i_dut (.mclk, .srst, .ce, .row_sel_n, .col_sel, .address, .read, .write, .writedata,
        .readdata, .waitrequest, .low_on, .high_on, .low_step, .high_step, .mute);
    dtd_keypad i_pad (.press_row, .press_col, .micro, .code, .tone_en, .row_sel_n, .col_sel);

    function automatic logic [31:0] xorshift();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    // status of a running microcomputer tone pair
    function automatic logic [31:0] micro_stat(input logic [1:0] l, input logic [1:0] h);
        return 32'h186 | (32'(l) << `DTD_STAT_LIDX) | (32'(h) << `DTD_STAT_HIDX);
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one bus cycle, optionally frozen by ce first
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic st);
        @(posedge mclk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        if (st) begin
            ce <= 1'b0;
            repeat (4) @(posedge mclk);
            check("stalled waitrequest", 32'h1, waitrequest);
            ce <= 1'b1;
        end
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check("bus answer", 32'h0, waitrequest);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wait_low_on(input logic v, input int lim);
        n = 0;
        while (low_on !== v && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (n >= lim) check("low_on wait", 32'(v), 32'(low_on));
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // period meters, wrap to wrap of each staircase
    always @(posedge mclk) begin
        lc <= lc + 1;
        hc <= hc + 1;
        if (low_step == 5'd0 && lp == 5'd13) begin
            lo_per <= lc + 1;
            lc <= 0;
        end
        if (high_step == 5'd0 && hp == 5'd17) begin
            hi_per <= hc + 1;
            hc <= 0;
        end
        lp <= low_step;
        hp <= high_step;
    end
    // tests need about 70k cycles
    initial begin
        repeat (95000) @(posedge mclk);
        mismatches++;
        $display("[FAIL] watchdog expected finish seen hang");
        wrap_up();
    end

    // ********
    // main sequence
    // ********
    initial begin
        srst = 1'b1;
        ce = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        writedata = 32'h0;
        press_row = 4'h0;
        press_col = 4'h0;
        micro = 1'b0;
        code = 4'hf;
        tone_en = 1'b0;
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        check("reset outputs", 32'h0, {low_on, high_on, mute});
        bus(1'b0, `DTD_CTRL_ADDR, 32'h0, 1'b1);
        check("ctrl reset", `DTD_CTRL_RST, q);
        bus(1'b1, `DTD_CTRL_ADDR, xorshift() & 32'hfffffffe, 1'b0);
        bus(1'b0, `DTD_CTRL_ADDR, 32'h0, 1'b0);
        check("ctrl enable", 32'h0, q[0]);
        bus(1'b1, `DTD_CTRL_ADDR, 32'h1, 1'b0);
        bus(1'b1, `DTD_STAT_ADDR, 32'hffffffff, 1'b0);
        bus(1'b0, `DTD_STAT_ADDR, 32'h0, 1'b0);
        check("idle status", 32'h0, q & 32'h187);
        bus(1'b1, 4'h8, xorshift(), 1'b0);
        bus(1'b0, 4'h8, 32'h0, 1'b0);
        check("unmapped read", 32'h0, q);
        // microcomputer drive with enable low: muted, silent
        r = xorshift();
        micro <= 1'b1;
        code <= r[3:0];
        repeat (40) @(posedge mclk);
        check("micro mute", 32'h1, {low_on, high_on, mute});
        // every code once, periods measured on the diagonal
        for (int k = 0; k < 16; k++) begin
            c = 4'(k) ^ r[7:4];
            li = ~c[3:2];
            hi = ~c[1:0];
            code <= c;
            tone_en <= 1'b1;
            repeat (40) @(posedge mclk);
            bus(1'b0, `DTD_STAT_ADDR, 32'h0, 1'b0);
            check("micro status", micro_stat(li, hi), q & 32'h1fe);
            if (li == hi) begin
                repeat (2 * PRE * lo_div[li] + 200) @(posedge mclk);
                check("low period", PRE * lo_div[li], lo_per);
                check("high period", PRE * hi_div[hi], hi_per);
            end
            tone_en <= 1'b0;
            repeat (40) @(posedge mclk);
            check("micro tone off", 32'h0, {low_on, high_on});
        end
        micro <= 1'b0;
        code <= 4'hf;
        repeat (40) @(posedge mclk);
        check("speech mode", 32'h0, {low_on, high_on, mute});
        // row-only key, then a full key pressed while it sounds
        press_row <= 4'h8;
        @(posedge mclk);
        wait_low_on(1'b1, 40);
        check("press latency", 32'h1, 32'(n <= 16));
        repeat (20) @(posedge mclk);
        check("single tone", 32'h5, {low_on, high_on, mute});
        r = xorshift();
        press_row <= 4'hc;
        press_col <= 4'h1 << r[1:0];
        repeat (300) @(posedge mclk);
        bus(1'b0, `DTD_STAT_ADDR, 32'h0, 1'b0);
        check("locked row", 32'h3, q[4:3]);
        check("locked column", 32'h0, high_on);
        press_row <= 4'h4;
        @(posedge mclk);
        wait_low_on(1'b0, 20000);
        nf = n;
        check("release hold", 32'h1, 32'(nf > 2 * PRE * lo_div[3]));
        wait_low_on(1'b1, 40);
        check("rollover start", 32'h1, 32'(n <= 16));
        repeat (20) @(posedge mclk);
        bus(1'b0, `DTD_STAT_ADDR, 32'h0, 1'b0);
        check("rollover status", 32'h194 | (32'(r[1:0]) << 5), q & 32'h1fc);
        press_row <= 4'h0;
        press_col <= 4'h0;
        @(posedge mclk);
        wait_low_on(1'b0, 30000);
        check("release hold b", 32'h1, 32'(n > 2 * PRE * lo_div[2]));
        repeat (20) @(posedge mclk);
        check("idle again", 32'h0, {low_on, high_on, mute});
        wrap_up();
    end
endmodule
